// ---- logic/fei_regs.vh ----
// Register offsets, field positions and reset values of the flush event interrupt block.
`ifndef FEI_REGS_VH
`define FEI_REGS_VH
`define FEI_OFF_STATUS      8'h9c
`define FEI_OFF_CONTROL     8'ha0
`define FEI_OFF_DATA        8'ha4
`define FEI_OFF_ADDR        8'ha8
`define FEI_OFF_UADDR       8'hac
`define FEI_OFF_IRQ_STATUS  8'hb0
`define FEI_OFF_IRQ_MASK    8'hb4
`define FEI_BIT_MASK        31
`define FEI_BIT_PENDING     30
`define FEI_BIT_WAIT_DONE   0
`define FEI_RST_MASK        1'b1
`define FEI_RST_ZERO        32'h0000_0000
`define FEI_ADDR_LOW_ZERO   2'b00
`define FEI_IRQ_BITS        2
`define FEI_IRQ_EV_DONE     0
`define FEI_IRQ_EV_SENT     1
`endif

// ---- logic/fei_sticky.v ----
// Sticky event flags with write-one-to-clear; a set in the clearing cycle wins.
`timescale 1ns/1ps
module fei_sticky #(
    parameter WIDTH = 2
) (
    // Clock and reset.
    input  wire             clk,
    input  wire             reset,
    // Events and clear.
    input  wire [WIDTH-1:0] set_pulse,
    input  wire [WIDTH-1:0] clear_ones,
    // Flags.
    output wire [WIDTH-1:0] flags
);
    reg [WIDTH-1:0] flag_q;
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_flag
            always @(posedge clk)
            begin
                if (reset)
                    flag_q[i] <= 1'b0;
                else if (set_pulse[i])
                    flag_q[i] <= 1'b1;
                else if (clear_ones[i])
                    flag_q[i] <= 1'b0;
            end
        end
    endgenerate
    assign flags = flag_q;
endmodule

// ---- logic/fei_msg_sender.v ----
// Issues one posted message write per request and holds it until the fabric accepts.
`timescale 1ns/1ps
`include "fei_regs.vh"
module fei_msg_sender (
    // Clock and reset.
    input  wire        clk,
    input  wire        reset,
    // Request from the controller.
    input  wire        send_req,
    input  wire [63:0] send_addr,
    input  wire [31:0] send_data,
    output wire        send_busy,
    output wire        send_done,
    // Posted write to the interrupt fabric.
    output wire        msg_valid,
    input  wire        msg_ready,
    output wire [63:0] msg_addr,
    output wire [31:0] msg_data
);
    reg        valid_q;
    reg        done_q;
    reg [63:0] addr_q;
    reg [31:0] data_q;
    always @(posedge clk)
    begin
        if (reset)
        begin
            valid_q <= 1'b0;
            done_q  <= 1'b0;
            addr_q  <= 64'h0000_0000_0000_0000;
            data_q  <= `FEI_RST_ZERO;
        end
        else
        begin
            done_q <= valid_q & msg_ready;
            if (valid_q & msg_ready)
                valid_q <= 1'b0;
            else if (!valid_q & send_req)
            begin
                valid_q <= 1'b1;
                addr_q  <= send_addr;
                data_q  <= send_data;
            end
        end
    end
    assign send_busy = valid_q;
    assign send_done = done_q;
    assign msg_valid = valid_q;
    assign msg_addr  = addr_q;
    assign msg_data  = data_q;
endmodule

// ---- logic/fei_top.v ----
// Flush completion event interrupt generator with its register file.
`timescale 1ns/1ps
`include "fei_regs.vh"
module fei_top #(
    parameter WIDE_DATA    = 1,
    parameter WIDE_ADDR    = 1,
    parameter QUEUED_FLUSH = 1
) (
    // Clock and reset.
    input  wire        clk,
    input  wire        reset,
    // Register port.
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_write,
    input  wire        reg_read,
    output reg  [31:0] reg_rdata,
    // Completion of a wait descriptor with notify set.
    input  wire        wait_notify_done,
    // Transient hold from the unit's internal logic.
    input  wire        hold_transient,
    // Message write to the interrupt fabric.
    output wire        msg_valid,
    input  wire        msg_ready,
    output wire [63:0] msg_addr,
    output wire [31:0] msg_data,
    // Level interrupt to the local controller.
    output reg         irq
);
    wire       qi_on = (QUEUED_FLUSH != 0);
    reg        mask_q;
    reg        pending_q;
    reg        wait_done_q;
    reg [31:0] data_q;
    reg [29:0] addr_q;
    reg [31:0] uaddr_q;
    reg [`FEI_IRQ_BITS-1:0] irq_mask_q;
    wire [`FEI_IRQ_BITS-1:0] irq_flags;
    wire       send_busy;
    wire       send_done;

    wire wr_status  = reg_write & (reg_addr == `FEI_OFF_STATUS);
    wire wr_control = reg_write & (reg_addr == `FEI_OFF_CONTROL);
    wire wr_data    = reg_write & (reg_addr == `FEI_OFF_DATA);
    wire wr_addr    = reg_write & (reg_addr == `FEI_OFF_ADDR);
    wire wr_uaddr   = reg_write & (reg_addr == `FEI_OFF_UADDR);
    wire wr_istat   = reg_write & (reg_addr == `FEI_OFF_IRQ_STATUS);
    wire wr_imask   = reg_write & (reg_addr == `FEI_OFF_IRQ_MASK);

    // A completion counts only while the wait flag is clear.
    wire new_cond  = qi_on & wait_notify_done & ~wait_done_q;
    // Servicing the flag drops a pending message that has not yet gone to the sender.
    wire serviced  = wr_status & reg_wdata[`FEI_BIT_WAIT_DONE] & wait_done_q;
    // Send only when unmasked and no transient hold; the sender takes one at a time.
    wire fire      = pending_q & ~mask_q & ~hold_transient & ~send_busy & ~serviced;
    wire [31:0] payload = WIDE_DATA ? data_q : {16'h0000, data_q[15:0]};
    wire [31:0] upper   = WIDE_ADDR ? uaddr_q : `FEI_RST_ZERO;

    always @(posedge clk)
    begin
        if (reset)
        begin
            mask_q      <= `FEI_RST_MASK;
            pending_q   <= 1'b0;
            wait_done_q <= 1'b0;
            data_q      <= `FEI_RST_ZERO;
            addr_q      <= 30'h0000_0000;
            uaddr_q     <= `FEI_RST_ZERO;
            irq_mask_q  <= {`FEI_IRQ_BITS{1'b0}};
        end
        else
        begin
            // Set wins over the write-one clear.
            if (new_cond)
                wait_done_q <= 1'b1;
            else if (wr_status & reg_wdata[`FEI_BIT_WAIT_DONE])
                wait_done_q <= 1'b0;
            // Pending stays until sent or serviced; the send clears it at once.
            if (new_cond)
                pending_q <= 1'b1;
            else if (fire | serviced)
                pending_q <= 1'b0;
            if (wr_control & qi_on)
                mask_q <= reg_wdata[`FEI_BIT_MASK];
            if (wr_data & qi_on)
                data_q <= reg_wdata;
            if (wr_addr & qi_on)
                addr_q <= reg_wdata[31:2];
            if (wr_uaddr)
                uaddr_q <= reg_wdata;
            if (wr_imask)
                irq_mask_q <= reg_wdata[`FEI_IRQ_BITS-1:0];
        end
    end

    fei_sticky #(
        .WIDTH (`FEI_IRQ_BITS)
    ) u_sticky (
        .clk        (clk),
        .reset      (reset),
        .set_pulse  ({send_done, new_cond}),
        .clear_ones (wr_istat ? reg_wdata[`FEI_IRQ_BITS-1:0] : {`FEI_IRQ_BITS{1'b0}}),
        .flags      (irq_flags)
    );

    fei_msg_sender u_sender (
        .clk       (clk),
        .reset     (reset),
        .send_req  (fire),
        .send_addr ({upper, addr_q, `FEI_ADDR_LOW_ZERO}),
        .send_data (payload),
        .send_busy (send_busy),
        .send_done (send_done),
        .msg_valid (msg_valid),
        .msg_ready (msg_ready),
        .msg_addr  (msg_addr),
        .msg_data  (msg_data)
    );

    // Reads answer one cycle later; queued-flush registers except the upper address read zero when unsupported.
    always @(posedge clk)
    begin
        if (reset)
        begin
            reg_rdata <= `FEI_RST_ZERO;
            irq       <= 1'b0;
        end
        else
        begin
            irq       <= |(irq_flags & irq_mask_q);
            reg_rdata <= `FEI_RST_ZERO;
            if (reg_read)
            begin
                case (reg_addr)
                    `FEI_OFF_STATUS:
                        reg_rdata <= {31'h0000_0000, wait_done_q & qi_on};
                    `FEI_OFF_CONTROL:
                        reg_rdata <= qi_on ? {mask_q, pending_q, 30'h0000_0000}
                                           : `FEI_RST_ZERO;
                    `FEI_OFF_DATA:
                        reg_rdata <= qi_on ? payload : `FEI_RST_ZERO;
                    `FEI_OFF_ADDR:
                        reg_rdata <= qi_on ? {addr_q, `FEI_ADDR_LOW_ZERO} : `FEI_RST_ZERO;
                    `FEI_OFF_UADDR:
                        reg_rdata <= upper;
                    `FEI_OFF_IRQ_STATUS:
                        reg_rdata <= {30'h0000_0000, irq_flags};
                    `FEI_OFF_IRQ_MASK:
                        reg_rdata <= {30'h0000_0000, irq_mask_q};
                    default:
                        reg_rdata <= `FEI_RST_ZERO;
                endcase
            end
        end
    end
endmodule

// ---- dv/fei_fabric_model.sv ----
// Interrupt fabric model that takes posted message writes.
`timescale 1ns/1ps
module fei_fabric_model (
    // Clock.
    input  wire  clk,
    // Posted write from the block.
    input  wire  msg_valid,
    output logic msg_ready,
    // Stall control and count of writes taken.
    input  wire  stall,
    output int   taken
);
    // A stalled fabric keeps ready low, so the block must hold its offer up.
    assign msg_ready = !stall;
    initial taken = 0;
    always @(posedge clk)
        taken <= taken + int'(msg_valid && msg_ready);
endmodule

// ---- dv/fei_top_monitor.sv ----
// Assertion checker for the flush event interrupt generator.
`timescale 1ns/1ps
module fei_top_monitor (
    // Clock and reset.
    input wire        clk,
    input wire        reset,
    // Register port.
    input wire [7:0]  reg_addr,
    input wire [31:0] reg_wdata,
    input wire        reg_write,
    input wire        reg_read,
    input wire [31:0] reg_rdata,
    // Events and message link.
    input wire        wait_notify_done,
    input wire        hold_transient,
    input wire        msg_valid,
    input wire        msg_ready,
    input wire [63:0] msg_addr,
    input wire [31:0] msg_data
);
    // Shadows rebuilt from register traffic; a set beats a clear in one cycle.
    logic mask_q;
    logic wflag_q;
    wire  clr = reg_write && reg_addr == 8'h9c && reg_wdata[0];
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    always @(posedge clk)
    begin
        mask_q  <= reset | (reg_write && reg_addr == 8'ha0 ? reg_wdata[31] : mask_q);
        wflag_q <= !reset && (wait_notify_done || (wflag_q && !clr));
    end
    sequence new_cond;
        wait_notify_done && !wflag_q && !mask_q && !msg_valid;
    endsequence
    sequence free_path;
        !hold_transient && !mask_q && !reg_write && !msg_valid;
    endsequence
    AST_SEND: assert property (new_cond ##1 free_path |=> msg_valid)
        else $error("no message for open condition");
    AST_MASKED: assert property (mask_q && !msg_valid |=> !msg_valid)
        else $error("message while masked");
    AST_HELD: assert property (hold_transient && !msg_valid |=> !msg_valid)
        else $error("message while held");
    AST_STAND: assert property (msg_valid && !msg_ready |=>
        msg_valid && $stable(msg_addr) && $stable(msg_data)) else $error("offer dropped");
    AST_ONCE: assert property (msg_valid && msg_ready |=> !msg_valid)
        else $error("message repeated");
    AST_ALIGN: assert property (msg_valid |-> msg_addr[1:0] == 2'h0)
        else $error("message address unaligned");
    AST_RD_CTL: assert property (reg_read && reg_addr == 8'ha0 |=>
        reg_rdata[31] == $past(mask_q) && reg_rdata[29:0] == 30'h0) else $error("control read");
    AST_RD_WAIT: assert property (reg_read && reg_addr == 8'h9c |=>
        reg_rdata == {31'h0, $past(wflag_q)}) else $error("status read");
    AST_RD_ADDR: assert property (reg_read && reg_addr == 8'ha8 |=> reg_rdata[1:0] == 2'h0)
        else $error("address low bits");
endmodule
bind fei_top fei_top_monitor u_mon (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .wait_notify_done(wait_notify_done), .hold_transient(hold_transient), .msg_valid(msg_valid),
    .msg_ready(msg_ready), .msg_addr(msg_addr), .msg_data(msg_data));

// ---- dv/fei_top_tb_top.sv ----
// Self-checking testbench of the flush event interrupt generator.
`timescale 1ns/1ps
module fei_top_tb_top;
    logic        clk, reset, reg_write, reg_read, wait_notify_done, hold_transient, stall;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, dv, av, uv, reg_rdata, msg_data;
    logic [63:0] msg_addr;
    logic        msg_valid, msg_ready, irq;
    int          taken, mismatches, compares, cyc, seed;
    fei_top u_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .wait_notify_done(wait_notify_done), .hold_transient(hold_transient),
        .msg_valid(msg_valid), .msg_ready(msg_ready), .msg_addr(msg_addr),
        .msg_data(msg_data), .irq(irq));
    fei_fabric_model u_fab (.clk(clk), .msg_valid(msg_valid), .msg_ready(msg_ready),
        .stall(stall), .taken(taken));
    function logic [63:0] exp_addr(input logic [31:0] u, input logic [31:0] a);
        return {u, a[31:2], 2'h0};
    endfunction
    task chk(input string n, input logic [63:0] e, input logic [63:0] g);
        compares++;
        if (g !== e)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'h1;
        @(posedge clk);
        reg_write <= 1'h0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'h1;
        @(posedge clk);
        reg_read <= 1'h0;
        #1 chk("rdata", e, reg_rdata);
    endtask
    task ev;
        @(posedge clk);
        wait_notify_done <= 1'h1;
        @(posedge clk);
        wait_notify_done <= 1'h0;
        wt(4);
    endtask
    task stop_test;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    // The run needs under a hundred cycles; the ceiling leaves ample slack.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            mismatches++;
            stop_test;
        end
    end
    initial
    begin
        {reset, reg_write, reg_read, wait_notify_done, hold_transient, stall} = 6'h20;
        {reg_addr, reg_wdata, mismatches, compares, cyc, seed} = {40'h0, 96'h0, 32'h3889};
        repeat (12) @(posedge clk);
        reset <= 1'h0;
        rd(8'ha0, 32'h8000_0000);
        rd(8'ha4, 32'h0000_0000);
        rd(8'hc0, 32'h0000_0000);
        dv = $random(seed);
        av = $random(seed);
        uv = $random(seed);
        wr(8'ha4, dv);
        wr(8'ha8, av);
        wr(8'hac, uv);
        rd(8'ha4, dv);
        rd(8'ha8, {av[31:2], 2'h0});
        rd(8'hac, uv);
        ev;
        ev;
        rd(8'h9c, 32'h0000_0001);
        rd(8'ha0, 32'hc000_0000);
        chk("taken", 0, taken);
        @(posedge clk) stall <= 1'h1;
        wr(8'ha0, 32'h0000_0000);
        wt(4);
        chk("addr", exp_addr(uv, av), msg_addr);
        chk("data", dv, msg_data);
        @(posedge clk) stall <= 1'h0;
        wt(3);
        chk("taken", 1, taken);
        rd(8'ha0, 32'h0000_0000);
        wr(8'h9c, 32'h0000_0001);
        @(posedge clk) hold_transient <= 1'h1;
        ev;
        rd(8'ha0, 32'h4000_0000);
        wr(8'h9c, 32'h0000_0001);
        rd(8'ha0, 32'h0000_0000);
        @(posedge clk) hold_transient <= 1'h0;
        wt(4);
        chk("taken", 1, taken);
        ev;
        chk("taken", 2, taken);
        chk("irq", 0, irq);
        wr(8'hb4, 32'h0000_0003);
        wt(2);
        chk("irq", 1, irq);
        wr(8'hb0, 32'h0000_0003);
        wt(2);
        chk("irq", 0, irq);
        stop_test;
    end
endmodule
